// ---- rtl/iid_ident_reg.sv ----
// Function
// - Lock set by one when both interfaces capable, zero ignored
// - Initialisation event clears the lock
// - Selection codes; effect at next initialisation
// - Selection writes only while unlocked
// - Future capability field reads zero
// - Buffer capable bit shows support
// - FIFO capable bit shows support
// - Reserved span reads zero
// - Locality bit shows five localities
// - Revision field encodes interface version
// - Kind field encodes active interface
// - Kind 1111 means older FIFO generation
// - Never report kind 1111
// - Writes to kind field discarded
// - FIFO kind reports revision zero
// - Buffer kind reports revision one
// - Revision follows active kind
// - FIFO active enables cancel and reset controls
// - Exactly one interface active from the first clock after reset
// - Multi locality enables forced takeover
// - Single locality: no forced takeover
// - Same contents at every locality
`timescale 1ns/1ps

module iid_ident_reg #(
    parameter bit FIFO_CAPABLE = 1'b1,
    parameter bit BUF_CAPABLE = 1'b1,
    parameter bit MULTI_LOCALITY = 1'b1
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic init_event_i,
    output logic fifo_active_o,
    output logic buf_active_o,
    output logic cancel_ctrl_en_o,
    output logic takeover_en_o
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    // One interface must exist
    if (!FIFO_CAPABLE && !BUF_CAPABLE)
    begin : g_no_intf
        $error("at least one interface must be capable");
    end

    if (iid_pkg::LOCALITIES != 5)
    begin : g_bad_loc
        $error("locality count must be five");
    end

    if (iid_pkg::KIND_FIFO == iid_pkg::KIND_OLD_FIFO || iid_pkg::KIND_BUF == iid_pkg::KIND_OLD_FIFO)
    begin : g_bad_kind
        $error("kind codes must differ from older FIFO code");
    end

    // ************************************************************
    // Synchroniser for the initialisation pin
    // ************************************************************
    logic [2:0] init_sync;
    logic init_seen;
    logic init_pulse;

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            init_sync <= 3'h0;
        end
        else
        begin
            init_sync <= {init_sync[1:0], init_event_i};
        end
    end

    // Filtered level: changes once stages two and three agree
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            init_seen <= 1'b0;
        end
        else if (init_sync[1] == init_sync[2])
        begin
            init_seen <= init_sync[2];
        end
    end

    assign init_pulse = (init_sync[1] == init_sync[2]) && init_sync[2] && !init_seen;

    // ************************************************************
    // Bus decode
    // ************************************************************
    logic req;
    logic sw_init;
    logic hit_ident;
    logic hit_init;
    logic hit_status;
    logic do_init;
    logic wr_ident;

    function automatic logic is_ident(input logic [15:0] adr);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < iid_pkg::LOCALITIES; i++)
        begin
            if (adr == 16'(iid_pkg::IDENT_OFFSET + 16'(i) * iid_pkg::LOC_STRIDE))
            begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;

    always_comb
    begin
        hit_ident = 1'b0;
        hit_init = 1'b0;
        hit_status = 1'b0;
        if (is_ident(wb_adr_i))
        begin
            hit_ident = 1'b1;
        end
        else if (wb_adr_i == iid_pkg::INIT_CTRL_OFFSET)
        begin
            hit_init = 1'b1;
        end
        else if (wb_adr_i == iid_pkg::STATUS_OFFSET)
        begin
            hit_status = 1'b1;
        end
    end

    assign sw_init = req && wb_we_i && hit_init && wb_sel_i[0] && wb_dat_i[iid_pkg::INIT_BIT];
    assign do_init = init_pulse || sw_init;
    assign wr_ident = req && wb_we_i && hit_ident && wb_sel_i[2];

    // ************************************************************
    // Lock, selection and active kind
    // ************************************************************
    logic lock;
    logic [1:0] sel;
    logic [3:0] kind;
    logic both_cap;
    logic [1:0] wsel;
    logic [1:0] next_sel;

    assign both_cap = FIFO_CAPABLE && BUF_CAPABLE;
    assign wsel = wb_dat_i[iid_pkg::SEL_HI:iid_pkg::SEL_LO];

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            lock <= iid_pkg::LOCK_RESET;
        end
        else if (do_init)
        begin
            lock <= 1'b0;
        end
        else if (wr_ident && both_cap && wb_dat_i[iid_pkg::LOCK_BIT])
        begin
            lock <= 1'b1;
        end
    end

    always_comb
    begin
        next_sel = sel;
        if (wr_ident && both_cap && !lock)
        begin
            if (wsel == iid_pkg::SEL_FIFO || wsel == iid_pkg::SEL_BUF)
            begin
                next_sel = wsel;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sel <= iid_pkg::SEL_RESET;
        end
        else if (!do_init)
        begin
            sel <= next_sel;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            kind <= iid_pkg::KIND_FIFO;
        end
        else if (do_init)
        begin
            if (sel == iid_pkg::SEL_BUF && BUF_CAPABLE)
            begin
                kind <= iid_pkg::KIND_BUF;
            end
            else if (FIFO_CAPABLE)
            begin
                kind <= iid_pkg::KIND_FIFO;
            end
            else
            begin
                kind <= iid_pkg::KIND_BUF;
            end
        end
    end

    // ************************************************************
    // Register image
    // ************************************************************
    logic [31:0] ident_word;
    logic [3:0] rev;

    assign rev = (kind == iid_pkg::KIND_BUF) ? iid_pkg::REV_BUF : iid_pkg::REV_FIFO;

    always_comb
    begin
        ident_word = 32'h0;
        ident_word[iid_pkg::KIND_HI:iid_pkg::KIND_LO] = kind;
        ident_word[iid_pkg::REV_HI:iid_pkg::REV_LO] = rev;
        ident_word[iid_pkg::LOC_BIT] = MULTI_LOCALITY;
        ident_word[iid_pkg::RSV_HI:iid_pkg::RSV_LO] = 4'h0;
        ident_word[iid_pkg::FIFO_CAP_BIT] = FIFO_CAPABLE;
        ident_word[iid_pkg::CRB_CAP_BIT] = BUF_CAPABLE;
        ident_word[iid_pkg::FUTCAP_HI:iid_pkg::FUTCAP_LO] = 2'h0;
        ident_word[iid_pkg::SEL_HI:iid_pkg::SEL_LO] = sel;
        ident_word[iid_pkg::LOCK_BIT] = lock;
    end

    // ************************************************************
    // Wishbone answer
    // ************************************************************
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            wb_ack_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= req && (hit_ident || hit_init || hit_status);
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            wb_err_o <= 1'b0;
        end
        else
        begin
            wb_err_o <= req && !(hit_ident || hit_init || hit_status);
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            wb_dat_o <= 32'h0;
        end
        else if (req && !wb_we_i && hit_ident)
        begin
            wb_dat_o <= ident_word;
        end
        else if (req && !wb_we_i && hit_status)
        begin
            wb_dat_o <= {28'h0, takeover_en_o, cancel_ctrl_en_o, buf_active_o,
                fifo_active_o};
        end
        else
        begin
            wb_dat_o <= 32'h0;
        end
    end

    // ************************************************************
    // Active interface outputs
    // ************************************************************
    // One active at a time
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            fifo_active_o <= 1'b0;
        end
        else
        begin
            fifo_active_o <= (kind == iid_pkg::KIND_FIFO);
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            buf_active_o <= 1'b0;
        end
        else
        begin
            buf_active_o <= (kind == iid_pkg::KIND_BUF);
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cancel_ctrl_en_o <= 1'b0;
        end
        else
        begin
            cancel_ctrl_en_o <= (kind == iid_pkg::KIND_FIFO);
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            takeover_en_o <= 1'b0;
        end
        else
        begin
            takeover_en_o <= MULTI_LOCALITY;
        end
    end

endmodule // iid_ident_reg

// ---- rtl/iid_pkg.sv ----
package iid_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    // Identifier register at offset 0x030 in each locality window
    localparam logic [15:0] IDENT_OFFSET = 16'h0030;
    // Spacing of locality windows
    localparam logic [15:0] LOC_STRIDE = 16'h1000;
    // Initialisation control register (own map)
    localparam logic [15:0] INIT_CTRL_OFFSET = 16'h0f00;
    // Active state status register (own map)
    localparam logic [15:0] STATUS_OFFSET = 16'h0f04;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int LOCK_BIT = 19;
    localparam int SEL_HI = 18;
    localparam int SEL_LO = 17;
    localparam int FUTCAP_HI = 16;
    localparam int FUTCAP_LO = 15;
    localparam int CRB_CAP_BIT = 14;
    localparam int FIFO_CAP_BIT = 13;
    localparam int RSV_HI = 12;
    localparam int RSV_LO = 9;
    localparam int LOC_BIT = 8;
    localparam int REV_HI = 7;
    localparam int REV_LO = 4;
    localparam int KIND_HI = 3;
    localparam int KIND_LO = 0;
    localparam int INIT_BIT = 0;

    // ************************************************************
    // Encodings and reset values
    // ************************************************************
    localparam logic [1:0] SEL_FIFO = 2'h0;
    localparam logic [1:0] SEL_BUF = 2'h1;
    localparam logic [3:0] KIND_FIFO = 4'h0;
    localparam logic [3:0] KIND_BUF = 4'h1;
    localparam logic [3:0] KIND_OLD_FIFO = 4'hf;
    localparam logic [3:0] REV_FIFO = 4'h0;
    localparam logic [3:0] REV_BUF = 4'h1;
    localparam logic LOCK_RESET = 1'b0;
    localparam logic [1:0] SEL_RESET = SEL_FIFO;
    localparam int LOCALITIES = 5;

endpackage

// ---- test/iid_asserts.sv ----
`timescale 1ns/1ps
module iid_asserts #(
    parameter bit FIFO_CAPABLE = 1'b1,
    parameter bit BUF_CAPABLE = 1'b1,
    parameter bit MULTI_LOCALITY = 1'b1
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic fifo_active_o,
    input wire logic buf_active_o,
    input wire logic cancel_ctrl_en_o,
    input wire logic takeover_en_o
);
    // ********
    // Decode and checks
    // ********
    logic id_hit;
    logic mapped;
    assign id_hit = wb_adr_i[11:0] == 12'h030 && wb_adr_i[15:12] < 4'h5;
    assign mapped = id_hit || wb_adr_i == 16'h0f00 || wb_adr_i == 16'h0f04;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o; endsequence
    sequence s_rd; wb_ack_o && !wb_we_i && id_hit; endsequence
    property p_ack; s_req ##0 mapped |=> wb_ack_o && !wb_err_o; endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_err; s_req ##0 !mapped |=> wb_err_o && !wb_ack_o; endproperty
    a_err: assert property (p_err) else $error("no err");
    property p_pulse; wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o; endproperty
    a_pulse: assert property (p_pulse) else $error("long answer");
    property p_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("data outside ack");
    property p_fields;
        s_rd |-> {wb_dat_o[31:20], wb_dat_o[16:8]} ==
            {12'h0, 2'h0, BUF_CAPABLE, FIFO_CAPABLE, 4'h0, MULTI_LOCALITY};
    endproperty
    a_fields: assert property (p_fields) else $error("bad fixed field");
    property p_kind; s_rd |-> wb_dat_o[3:0] != 4'hf && wb_dat_o[7:4] == wb_dat_o[3:0]; endproperty
    a_kind: assert property (p_kind) else $error("bad kind");
    property p_one; $past(arst_n_i) |-> fifo_active_o != buf_active_o; endproperty
    a_one: assert property (p_one) else $error("active count");
    property p_ctrl;
        $past(arst_n_i) |-> cancel_ctrl_en_o == fifo_active_o && takeover_en_o == MULTI_LOCALITY;
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("bad controls");
endmodule // iid_asserts

bind iid_ident_reg iid_asserts #(
    .FIFO_CAPABLE(FIFO_CAPABLE), .BUF_CAPABLE(BUF_CAPABLE), .MULTI_LOCALITY(MULTI_LOCALITY)
) iid_asserts_i (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .fifo_active_o(fifo_active_o), .buf_active_o(buf_active_o),
    .cancel_ctrl_en_o(cancel_ctrl_en_o), .takeover_en_o(takeover_en_o)
);

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    typedef struct {logic w; logic [15:0] a; logic [31:0] d;} iid_row_t;
    iid_row_t rows[$];
    iid_row_t r;
    logic clk = 1'h0, rst_n = 1'h0, cyc = 1'h0, we = 1'h0, ini = 1'h0;
    logic [3:0] sel = 4'h0;
    logic [15:0] adr = 16'h0;
    logic [31:0] wd = 32'h0, rdat, rd;
    logic ack, err, er, fa, ba, ce, te;
    int bad_count = 0;
    int n_checks = 0;
    always #4 clk = ~clk;
    iid_ident_reg iid_ident_reg_i (
        .sys_clk_i(clk), .arst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
        .wb_err_o(err), .init_event_i(ini), .fifo_active_o(fa), .buf_active_o(ba),
        .cancel_ctrl_en_o(ce), .takeover_en_o(te));
    // ********
    // Tasks
    // ********
    task print_verdict;
        if (bad_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
            bad_count++;
        end
    endtask
    task fail_out;
        bad_count++;
        print_verdict();
    endtask
    task bus(input logic w, input logic [3:0] s, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'h1;
        we <= w;
        sel <= s;
        adr <= a;
        wd <= d;
        @(posedge clk);
        repeat (20) if (ack !== 1'h1 && err !== 1'h1) @(posedge clk);
        if (ack !== 1'h1 && err !== 1'h1)
            fail_out();
        rd = rdat;
        er = err;
        cyc <= 1'h0;
    endtask
    task add(input logic w, input logic [15:0] a, input logic [31:0] d);
        rows.push_back('{w, a, d});
    endtask
    task run;
        while (rows.size() > 0)
        begin
            r = rows.pop_front();
            bus(r.w, 4'hf, r.a, r.d);
            if (!r.w)
                chk(rd, r.d);
            chk({31'h0, er}, 32'h0);
            if (r.a == 16'h0f00)
                repeat (6) @(posedge clk);
        end
    endtask
    // ********
    // Sequence
    // ********
    initial
    begin
        add(1'h0, 16'h0030, 32'h00006100);
        add(1'h0, 16'h1030, 32'h00006100);
        add(1'h0, 16'h4030, 32'h00006100);
        add(1'h1, 16'h0030, 32'h0000000f);
        add(1'h1, 16'h0030, 32'h00060000);
        add(1'h0, 16'h0030, 32'h00006100);
        add(1'h1, 16'h0030, 32'h00020000);
        add(1'h0, 16'h0030, 32'h00026100);
        add(1'h0, 16'h0f04, 32'h0000000d);
        add(1'h1, 16'h0f00, 32'h00000001);
        add(1'h0, 16'h0030, 32'h00026111);
        add(1'h0, 16'h0f04, 32'h0000000a);
        add(1'h1, 16'h1030, 32'h000a0000);
        add(1'h1, 16'h0030, 32'h00000000);
        add(1'h0, 16'h0030, 32'h000a6111);
        add(1'h1, 16'h0f00, 32'h00000001);
        add(1'h0, 16'h0030, 32'h00026111);
        add(1'h1, 16'h0030, 32'h00000000);
        add(1'h0, 16'h0030, 32'h00006111);
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        run();
        bus(1'h0, 4'hf, 16'h5030, 32'h0);
        chk({31'h0, er}, 32'h1);
        bus(1'h1, 4'hb, 16'h0030, 32'h00020000);
        add(1'h0, 16'h0030, 32'h00006111);
        run();
        ini <= 1'h1;
        repeat (20) if (fa !== 1'h1) @(posedge clk);
        if (fa !== 1'h1)
            fail_out();
        ini <= 1'h0;
        chk({28'h0, fa, ba, ce, te}, 32'hb);
        add(1'h0, 16'h2030, 32'h00006100);
        add(1'h1, 16'h0030, 32'h00080000);
        add(1'h0, 16'h0030, 32'h00086100);
        run();
        rst_n <= 1'h0;
        repeat (3) @(posedge clk);
        chk({27'h0, ack, fa, ba, ce, te}, 32'h0);
        rst_n <= 1'h1;
        add(1'h0, 16'h0030, 32'h00006100);
        run();
        print_verdict();
    end
endmodule // testbench
